// ===== rtl/pll_cfg_pkg.sv
// shared constants, field layout and decode helpers for the clock setup block
package pll_cfg_pkg;

    // =====================================================================
    // widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int DVF_W  = 5;
    localparam int MLT_W  = 6;
    localparam int SEL_W  = 2;

    // =====================================================================
    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFF_SETUP  = 4'h0;  // clock_setup_register
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_RATIO  = 4'h8;

    // =====================================================================
    // field positions in clock_setup_register
    localparam int DVF_LSB = 0;
    localparam int MLT_LSB = 8;
    localparam int RNG_POS = 16;
    localparam int SEL_LSB = 20;

    // field positions in the status register
    localparam int ST_DIV_OK   = 0;
    localparam int ST_LOOP_OK  = 1;
    localparam int ST_CORE_OK  = 2;
    localparam int ST_DVF_OK   = 3;
    localparam int ST_RESERVED = 4;
    localparam int ST_REF_SEL  = 5;

    // field positions in the ratio register
    localparam int RT_NUM_LSB  = 0;
    localparam int RT_DEN_LSB  = 8;
    localparam int RT_VCO_LSB  = 16;
    localparam int RT_CORE_LSB = 20;

    // =====================================================================
    // reset values
    localparam logic [DVF_W-1:0] DVF_RST = 5'h00;
    localparam logic [MLT_W-1:0] MLT_RST = 6'h00;
    localparam logic             RNG_RST = 1'h1;
    localparam logic [SEL_W-1:0] SEL_RST = 2'h0;

    // =====================================================================
    // source select codes; 2'h2 also picks the reference
    localparam logic [SEL_W-1:0] SEL_REF      = 2'h0;
    localparam logic [SEL_W-1:0] SEL_VCO_HALF = 2'h1;
    localparam logic [SEL_W-1:0] SEL_VCO      = 2'h3;

    // =====================================================================
    // largest divide code and frequency limits in kHz
    localparam logic [31:0] DVF_MAX_CODE = 32'h00000009;
    localparam logic [31:0] DIV_MIN_KHZ  = 32'h00002710;  // 10 MHz
    localparam logic [31:0] DIV_MAX_KHZ  = 32'h000061a8;  // 25 MHz
    localparam logic [31:0] LOOP_MIN_KHZ = 32'h00040f10;  // 266 MHz
    localparam logic [31:0] LOOP_MAX_KHZ = 32'h00081e20;  // 532 MHz
    localparam logic [31:0] CORE_MAX_KHZ = 32'h00040f10;  // 266 MHz
    localparam logic [31:0] REF_MAX_KHZ  = 32'h000186a0;  // 100 MHz
    localparam int          REF_KHZ_DEF  = 40000;

    // division from loop to oscillator stage
    function automatic logic [1:0] vco_div(input logic vco_range_bit);
        vco_div = vco_range_bit ? 2'h1 : 2'h2;
    endfunction : vco_div

    // total division from loop to core; 1 also when the reference is picked
    function automatic logic [2:0] core_div(input logic [SEL_W-1:0] sel, input logic vco_range_bit);
        case (sel)
            SEL_VCO:      core_div = vco_range_bit ? 3'h1 : 3'h2;
            SEL_VCO_HALF: core_div = vco_range_bit ? 3'h2 : 3'h4;
            default:      core_div = 3'h1;
        endcase
    endfunction : core_div

    // the one forbidden pairing of select and range
    function automatic logic is_reserved(input logic [SEL_W-1:0] sel, input logic vco_range_bit);
        is_reserved = (sel == SEL_VCO) && vco_range_bit;
    endfunction : is_reserved

    // reference drives the core directly
    function automatic logic is_ref(input logic [SEL_W-1:0] sel);
        is_ref = (sel != SEL_VCO) && (sel != SEL_VCO_HALF);
    endfunction : is_ref

endpackage : pll_cfg_pkg

// ===== rtl/pll_cfg_if.sv
// configuration and status carrier between the setup block and its helpers
`timescale 1ns/1ps
interface pll_cfg_if;
    logic [pll_cfg_pkg::DVF_W-1:0] dvf;
    logic [pll_cfg_pkg::MLT_W-1:0] mlt;
    logic                          vco_range_bit;
    logic [pll_cfg_pkg::SEL_W-1:0] sel;
    logic                          div_tick;
    logic                          div_ok;
    logic                          loop_ok;
    logic                          core_ok;
    logic                          dvf_ok;

    modport ctrl (output dvf, output mlt, output vco_range_bit, output sel,
                  input div_tick, input div_ok, input loop_ok, input core_ok, input dvf_ok);
    modport div  (input dvf, output div_tick);
    modport chk  (input dvf, input mlt, input vco_range_bit, input sel,
                  output div_ok, output loop_ok, output core_ok, output dvf_ok);
endinterface : pll_cfg_if

// ===== rtl/ref_divider.sv
// input divider: one tick per (divide field + 1) reference cycles
`timescale 1ns/1ps
module ref_divider (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset,
    // configuration
    pll_cfg_if.div    cfg
);
    typedef struct packed {
        logic [pll_cfg_pkg::DVF_W-1:0] cnt;
        logic                          tick;
    } div_state_t;

    div_state_t q;
    div_state_t d;

    // =====================================================================
    // counter wraps at the field value, so a shrunken field never strands it
    always_comb begin
        d = q;
        d.tick = (q.cnt >= cfg.dvf);  // R1
        d.cnt  = d.tick ? '0 : pll_cfg_pkg::DVF_W'(q.cnt + 1'b1);
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cfg.div_tick = q.tick;

    // =====================================================================
    // tick marks exactly the wrap of the counter
    chk_tick_cause: assert property (@(posedge i_clk) disable iff (i_reset) // R1
        q.tick |-> $past(q.cnt) >= $past(cfg.dvf))
        else $error("divider tick without wrap");
    chk_tick_period: assert property (@(posedge i_clk) disable iff (i_reset) // R1
        (cfg.dvf == 5'h01) [*4] ##0 q.tick ##1 (cfg.dvf == 5'h01) |-> !q.tick ##1 q.tick)
        else $error("divide by two tick spacing wrong");

endmodule : ref_divider

// ===== rtl/cfg_window_check.sv
// checks the programmed setup against the permitted frequency windows
`timescale 1ns/1ps
module cfg_window_check #(
    parameter int REF_KHZ = pll_cfg_pkg::REF_KHZ_DEF
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset,
    // configuration
    pll_cfg_if.chk    cfg
);
    typedef struct packed {
        logic div_ok;
        logic loop_ok;
        logic core_ok;
        logic dvf_ok;
    } chk_state_t;

    localparam logic [31:0] REF = 32'(REF_KHZ);

    chk_state_t  q;
    chk_state_t  d;
    logic [31:0] den;
    logic [31:0] num;
    logic [31:0] ref_x_num;

    assign den       = 32'(cfg.dvf) + 32'h1;
    assign num       = 32'(cfg.mlt) + 32'h1;
    assign ref_x_num = REF * num;

    // =====================================================================
    // products avoid a divider: f/den in window <=> f in window*den
    always_comb begin
        d = q;
        d.div_ok  = (REF >= pll_cfg_pkg::DIV_MIN_KHZ * den)
                 && (REF <= pll_cfg_pkg::DIV_MAX_KHZ * den);            // R5
        d.loop_ok = (ref_x_num >= pll_cfg_pkg::LOOP_MIN_KHZ * den)
                 && (ref_x_num <= pll_cfg_pkg::LOOP_MAX_KHZ * den);     // R6
        d.dvf_ok  = (32'(cfg.dvf) <= pll_cfg_pkg::DVF_MAX_CODE);        // R7
        // bus runs at half the core, so the core bound covers both
        if (pll_cfg_pkg::is_ref(cfg.sel)) begin
            d.core_ok = (REF <= pll_cfg_pkg::CORE_MAX_KHZ);             // R9
        end else begin
            d.core_ok = ref_x_num <= pll_cfg_pkg::CORE_MAX_KHZ * den
                        * 32'(pll_cfg_pkg::core_div(cfg.sel, cfg.vco_range_bit)); // R9
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cfg.div_ok  = q.div_ok;
    assign cfg.loop_ok = q.loop_ok;
    assign cfg.core_ok = q.core_ok;
    assign cfg.dvf_ok  = q.dvf_ok;

    // =====================================================================
    chk_dvf_limit: assert property (@(posedge i_clk) disable iff (i_reset) // R7
        cfg.dvf > 5'h09 |=> !q.dvf_ok)
        else $error("oversized divide code not flagged");

endmodule : cfg_window_check

// ===== rtl/pll_cfg_top.sv
// clock setup register block: divider, multiplier ratio, range and core source
// ========================================================================
// Functional notes
// R1: reference divided by divide field plus one
// R2: loop ratio is multiply field plus one
// R3: range bit 1 passes loop, 0 halves
// R4: core source: reference, oscillator, or half oscillator
// R5: software keeps divider output at 10-25 MHz
// R6: software keeps loop output 266-532 MHz
// R7: divide codes above 0x09 never programmed
// R8: select 11 with range 1 is reserved
// R9: software keeps core <=266, bus <=133 MHz
`timescale 1ns/1ps
module pll_cfg_top #(
    parameter int REF_KHZ = pll_cfg_pkg::REF_KHZ_DEF
) (
    // clock and reset
    input  wire logic                           i_clk,
    input  wire logic                           i_reset,
    // register port
    input  wire logic [pll_cfg_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [pll_cfg_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                           i_wr,
    input  wire logic                           i_rd,
    output logic      [pll_cfg_pkg::DATA_W-1:0] o_rdata,
    // clock setup results
    output logic                                o_div_tick,
    output logic      [6:0]                     o_loop_num,
    output logic      [5:0]                     o_loop_den,
    output logic      [1:0]                     o_vco_div,
    output logic      [2:0]                     o_core_div,
    output logic                                o_core_from_ref,
    output logic                                o_setup_ok
);
    if (REF_KHZ < 1 || REF_KHZ > 100000) begin : g_bad_ref
        $error("REF_KHZ out of 1..100000");
    end

    typedef struct packed {
        logic [pll_cfg_pkg::DVF_W-1:0]  dvf;
        logic [pll_cfg_pkg::MLT_W-1:0]  mlt;
        logic                           vco_range_bit;
        logic [pll_cfg_pkg::SEL_W-1:0]  sel;
        logic                           reserved_seen;
        logic [pll_cfg_pkg::DATA_W-1:0] rdata;
        logic [6:0]                     loop_num;
        logic [5:0]                     loop_den;
        logic [1:0]                     vco_div;
        logic [2:0]                     core_div;
        logic                           core_ref;
        logic                           setup_ok;
    } top_state_t;

    top_state_t                    q;
    top_state_t                    d;
    pll_cfg_if                     cfg_bus ();
    logic [pll_cfg_pkg::DVF_W-1:0] w_dvf;
    logic [pll_cfg_pkg::MLT_W-1:0] w_mlt;
    logic                          w_rng;
    logic [pll_cfg_pkg::SEL_W-1:0] w_sel;
    logic                          w_setup;
    logic                          w_reserved;

    // =====================================================================
    // helpers
    ref_divider u_div (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .cfg     (cfg_bus.div)
    );

    cfg_window_check #(
        .REF_KHZ (REF_KHZ)
    ) u_chk (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .cfg     (cfg_bus.chk)
    );

    assign cfg_bus.dvf = q.dvf;
    assign cfg_bus.mlt = q.mlt;
    assign cfg_bus.vco_range_bit = q.vco_range_bit;
    assign cfg_bus.sel = q.sel;

    // =====================================================================
    // register images
    function automatic logic [pll_cfg_pkg::DATA_W-1:0] setup_image(input top_state_t s);
        setup_image = '0;
        setup_image[pll_cfg_pkg::DVF_LSB +: pll_cfg_pkg::DVF_W] = s.dvf;
        setup_image[pll_cfg_pkg::MLT_LSB +: pll_cfg_pkg::MLT_W] = s.mlt;
        setup_image[pll_cfg_pkg::RNG_POS]                       = s.vco_range_bit;
        setup_image[pll_cfg_pkg::SEL_LSB +: pll_cfg_pkg::SEL_W] = s.sel;
    endfunction : setup_image

    function automatic logic [pll_cfg_pkg::DATA_W-1:0] ratio_image(input top_state_t s);
        ratio_image = '0;
        ratio_image[pll_cfg_pkg::RT_NUM_LSB  +: 7] = s.loop_num;
        ratio_image[pll_cfg_pkg::RT_DEN_LSB  +: 6] = s.loop_den;
        ratio_image[pll_cfg_pkg::RT_VCO_LSB  +: 2] = s.vco_div;
        ratio_image[pll_cfg_pkg::RT_CORE_LSB +: 3] = s.core_div;
    endfunction : ratio_image

    // =====================================================================
    // write decode of the setup register
    assign w_dvf      = i_wdata[pll_cfg_pkg::DVF_LSB +: pll_cfg_pkg::DVF_W];
    assign w_mlt      = i_wdata[pll_cfg_pkg::MLT_LSB +: pll_cfg_pkg::MLT_W];
    assign w_rng      = i_wdata[pll_cfg_pkg::RNG_POS];
    assign w_sel      = i_wdata[pll_cfg_pkg::SEL_LSB +: pll_cfg_pkg::SEL_W];
    assign w_setup    = i_wr && (i_addr == pll_cfg_pkg::OFF_SETUP);
    assign w_reserved = pll_cfg_pkg::is_reserved(w_sel, w_rng);

    // =====================================================================
    // next state: register writes, read mux and derived ratios
    always_comb begin
        d = q;
        // a reserved pairing is refused whole so the core never sees it
        if (w_setup && !w_reserved) begin
            d.dvf = w_dvf;
            d.mlt = w_mlt;
            d.vco_range_bit = w_rng;
            d.sel = w_sel;
        end
        // writing status clears the flag; a refusal in the same cycle wins
        if (i_wr && (i_addr == pll_cfg_pkg::OFF_STATUS)) begin
            d.reserved_seen = 1'b0;
        end
        if (w_setup && w_reserved) begin
            d.reserved_seen = 1'b1;                                  // R8
        end
        // ratios follow the stored fields one cycle later
        d.loop_den = 6'(q.dvf) + 6'h1;                               // R1
        d.loop_num = 7'(q.mlt) + 7'h1;                               // R2
        d.vco_div  = pll_cfg_pkg::vco_div(q.vco_range_bit);                    // R3
        d.core_div = pll_cfg_pkg::core_div(q.sel, q.vco_range_bit);            // R4 R8
        d.core_ref = pll_cfg_pkg::is_ref(q.sel);                     // R4
        d.setup_ok = cfg_bus.div_ok && cfg_bus.loop_ok
                  && cfg_bus.core_ok && cfg_bus.dvf_ok;
        // read data valid only in the cycle after the strobe
        d.rdata = '0;
        if (i_rd) begin
            case (i_addr)
                pll_cfg_pkg::OFF_SETUP: begin
                    d.rdata = setup_image(q);
                end
                pll_cfg_pkg::OFF_STATUS: begin
                    d.rdata[pll_cfg_pkg::ST_DIV_OK]   = cfg_bus.div_ok;
                    d.rdata[pll_cfg_pkg::ST_LOOP_OK]  = cfg_bus.loop_ok;
                    d.rdata[pll_cfg_pkg::ST_CORE_OK]  = cfg_bus.core_ok;
                    d.rdata[pll_cfg_pkg::ST_DVF_OK]   = cfg_bus.dvf_ok;
                    d.rdata[pll_cfg_pkg::ST_RESERVED] = q.reserved_seen;
                    d.rdata[pll_cfg_pkg::ST_REF_SEL]  = q.core_ref;
                end
                pll_cfg_pkg::OFF_RATIO: begin
                    d.rdata = ratio_image(q);
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end
    end

    // =====================================================================
    // state register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            q          <= '0;
            q.dvf      <= pll_cfg_pkg::DVF_RST;
            q.mlt      <= pll_cfg_pkg::MLT_RST;
            q.vco_range_bit      <= pll_cfg_pkg::RNG_RST;
            q.sel      <= pll_cfg_pkg::SEL_RST;
            q.loop_num <= 7'h1;
            q.loop_den <= 6'h1;
            q.vco_div  <= 2'h1;
            q.core_div <= 3'h1;
            q.core_ref <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // =====================================================================
    // outputs
    assign o_rdata         = q.rdata;
    assign o_div_tick      = cfg_bus.div_tick;
    assign o_loop_num      = q.loop_num;
    assign o_loop_den      = q.loop_den;
    assign o_vco_div       = q.vco_div;
    assign o_core_div      = q.core_div;
    assign o_core_from_ref = q.core_ref;
    assign o_setup_ok      = q.setup_ok;

    // =====================================================================
    // checks
    chk_setup_store: assert property (@(posedge i_clk) disable iff (i_reset) // R1
        w_setup && !w_reserved |=> q.dvf == $past(w_dvf) && q.mlt == $past(w_mlt))
        else $error("setup write not stored");
    chk_loop_den: assert property (@(posedge i_clk) disable iff (i_reset) // R1
        w_setup && !w_reserved |-> ##2 o_loop_den == 6'($past(w_dvf, 2)) + 6'h1)
        else $error("divide ratio wrong");
    chk_loop_num: assert property (@(posedge i_clk) disable iff (i_reset) // R2
        w_setup && !w_reserved |-> ##2 o_loop_num == 7'($past(w_mlt, 2)) + 7'h1)
        else $error("multiply ratio wrong");
    chk_range_halve: assert property (@(posedge i_clk) disable iff (i_reset) // R3
        w_setup && !w_reserved |-> ##2 o_vco_div == ($past(w_rng, 2) ? 2'h1 : 2'h2))
        else $error("range halving wrong");
    chk_half_vco: assert property (@(posedge i_clk) disable iff (i_reset) // R4
        w_setup && !w_reserved && w_sel == pll_cfg_pkg::SEL_VCO_HALF && !w_rng
        |-> ##2 o_core_div == 3'h4 && !o_core_from_ref)
        else $error("half oscillator source wrong");
    chk_reserved_block: assert property (@(posedge i_clk) disable iff (i_reset) // R8
        w_setup && w_reserved |=> $stable(q.sel) && $stable(q.vco_range_bit) && q.reserved_seen)
        else $error("reserved setup accepted");
    chk_never_reserved: assert property (@(posedge i_clk) disable iff (i_reset) // R8
        !pll_cfg_pkg::is_reserved(q.sel, q.vco_range_bit))
        else $error("reserved pairing stored");
    chk_read_once: assert property (@(posedge i_clk) disable iff (i_reset)
        i_rd && i_addr == pll_cfg_pkg::OFF_SETUP && !i_wr
        |=> o_rdata == setup_image($past(q)) ##1 (o_rdata == '0 || $past(i_rd)))
        else $error("read data timing wrong");

    cov_reserved: cover property (@(posedge i_clk) disable iff (i_reset)
        w_setup && w_reserved);
    cov_vco_full: cover property (@(posedge i_clk) disable iff (i_reset)
        q.sel == pll_cfg_pkg::SEL_VCO && !q.vco_range_bit ##1 o_setup_ok);
    cov_ref_back: cover property (@(posedge i_clk) disable iff (i_reset)
        !o_core_from_ref ##[1:20] o_core_from_ref);

endmodule : pll_cfg_top

// ===== test/pll_core_clock_config_tb_top.sv
// self-checking bench for the clock setup register block
`timescale 1ns/1ps
module pll_core_clock_config_tb_top;
    // =================================================================
    // signals and bookkeeping
    logic        i_clk;
    logic        i_reset;
    logic [3:0]  i_addr;
    logic [31:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [31:0] o_rdata;
    logic        o_div_tick;
    logic [6:0]  o_loop_num;
    logic [5:0]  o_loop_den;
    logic [1:0]  o_vco_div;
    logic [2:0]  o_core_div;
    logic        o_core_from_ref;
    logic        o_setup_ok;
    int          err_total;
    int          comparisons;
    int          cycles;
    logic [31:0] val;
    int          gap;
    // select/range pairings and the total division each should give
    logic [1:0]  sel_tab [5] = '{2'h3, 2'h1, 2'h1, 2'h0, 2'h2};
    logic        rng_tab [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [2:0]  div_tab [5] = '{3'h2, 3'h2, 3'h4, 3'h1, 3'h1};

    // a slow 40 MHz reference keeps every window case reachable with small codes
    pll_cfg_top #(.REF_KHZ(40000)) DUT (
        .i_clk           (i_clk),
        .i_reset         (i_reset),
        .i_addr          (i_addr),
        .i_wdata         (i_wdata),
        .i_wr            (i_wr),
        .i_rd            (i_rd),
        .o_rdata         (o_rdata),
        .o_div_tick      (o_div_tick),
        .o_loop_num      (o_loop_num),
        .o_loop_den      (o_loop_den),
        .o_vco_div       (o_vco_div),
        .o_core_div      (o_core_div),
        .o_core_from_ref (o_core_from_ref),
        .o_setup_ok      (o_setup_ok)
    );

    // 25 ns reference period
    always #12.5 i_clk = ~i_clk;

    // hang guard: the whole run needs well under 2000 cycles
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            close_out();
        end
    end

    // =================================================================
    // verdict, compares and bus tasks
    task automatic close_out;
        if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected read data at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_port(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected port value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_port

    // each access starts on its own edge so no strobe is assigned twice in one step
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        @(negedge i_clk);
        d = o_rdata;
    endtask : rd

    // write the setup word, then wait until the window flag has caught up
    task automatic setup(input logic [4:0] dvf, input logic [5:0] mlt, input logic vco_range_bit,
                         input logic [1:0] sel);
        wr(4'h0, {10'h0, sel, 3'h0, vco_range_bit, 2'h0, mlt, 3'h0, dvf});
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
    endtask : setup

    // distance in cycles between two divider ticks
    task automatic tick_gap(output int n);
        n = 0;
        for (int k = 0; k < 40 && o_div_tick !== 1'b1; k++) @(negedge i_clk);
        do begin
            @(negedge i_clk);
            n++;
        end while (o_div_tick !== 1'b1 && n < 40);
    endtask : tick_gap

    // =================================================================
    // scenarios
    task automatic t_reset;
        rd(4'h0, val);
        chk_reg(val, 32'h00010000);
        rd(4'h8, val);
        chk_reg(val, 32'h00110101);
        rd(4'hc, val);
        chk_reg(val, 32'h00000000);
        chk_port({31'h0, o_setup_ok}, 32'h0);
    endtask : t_reset

    task automatic t_divide;
        logic [4:0] codes [3] = '{5'h00, 5'h03, 5'h09};
        foreach (codes[i]) begin
            setup(codes[i], 6'h0d, 1'b1, 2'h0);
            chk_port({26'h0, o_loop_den}, 32'(codes[i]) + 32'h1);
            tick_gap(gap);
            chk_port(32'(gap), 32'(codes[i]) + 32'h1);
        end
    endtask : t_divide

    task automatic t_multiply;
        logic [5:0] codes [3] = '{6'h00, 6'h0d, 6'h3f};
        foreach (codes[i]) begin
            setup(5'h01, codes[i], 1'b0, 2'h3);
            chk_port({25'h0, o_loop_num}, 32'(codes[i]) + 32'h1);
            rd(4'h8, val);
            chk_reg({25'h0, val[6:0]}, 32'(codes[i]) + 32'h1);
        end
    endtask : t_multiply

    task automatic t_select;
        foreach (sel_tab[i]) begin
            setup(5'h01, 6'h0d, rng_tab[i], sel_tab[i]);
            chk_port({30'h0, o_vco_div}, rng_tab[i] ? 32'h1 : 32'h2);
            chk_port({29'h0, o_core_div}, {29'h0, div_tab[i]});
            chk_port({31'h0, o_core_from_ref}, {31'h0, !sel_tab[i][0]});
        end
    endtask : t_select

    task automatic t_reserved;
        setup(5'h01, 6'h0d, 1'b0, 2'h3);
        setup(5'h05, 6'h02, 1'b1, 2'h3);
        rd(4'h0, val);
        chk_reg(val, 32'h00300d01);
        chk_port({29'h0, o_core_div}, 32'h2);
        rd(4'h4, val);
        chk_reg({31'h0, val[4]}, 32'h1);
        wr(4'h4, 32'h0);
        rd(4'h4, val);
        chk_reg({31'h0, val[4]}, 32'h0);
    endtask : t_reserved

    // status low bits: divider ok, loop ok, core ok, code ok, -, reference picked
    task automatic win(input logic [4:0] dvf, input logic [5:0] mlt, input logic [1:0] sel,
                       input logic [31:0] exp);
        setup(dvf, mlt, 1'b0, sel);
        chk_port({31'h0, o_setup_ok}, {31'h0, exp == 32'h0f});
        rd(4'h4, val);
        chk_reg(val & 32'h2f, exp);
    endtask : win

    task automatic t_window;
        win(5'h01, 6'h0d, 2'h3, 32'h0f);
        win(5'h00, 6'h0d, 2'h3, 32'h08);
        win(5'h01, 6'h06, 2'h3, 32'h0d);
        win(5'h01, 6'h1a, 2'h3, 32'h09);
        win(5'h0a, 6'h0d, 2'h0, 32'h24);
    endtask : t_window

    // =================================================================
    // main sequence
    initial begin
        i_clk       = 1'b0;
        i_reset     = 1'b1;
        i_addr      = 4'h0;
        i_wdata     = 32'h0;
        i_wr        = 1'b0;
        i_rd        = 1'b0;
        err_total   = 0;
        comparisons = 0;
        cycles      = 0;
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        t_reset();
        t_divide();
        t_multiply();
        t_select();
        t_reserved();
        t_window();
        close_out();
    end
endmodule : pll_core_clock_config_tb_top
